// *** hdl/uof_pkg.sv ***
// constants shared by the usb event flag block and its timer
package uof_pkg;

  // clock and line timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LINE_HOLD_NS = 2500;
  localparam int unsigned IDLE_HOLD_NS = 3000000;
  // least times, so round up to whole cycles
  localparam int unsigned LINE_HOLD_CYC = (LINE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IDLE_HOLD_CYC = (IDLE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 16;

  // register indices and byte addresses
  localparam logic [15:0] FLAGS_IDX = 16'h060A;
  localparam logic [15:0] ENABLES_IDX = 16'h060C;
  localparam logic [15:0] FLAGS_ADDR = {FLAGS_IDX[13:0], 2'b00};
  localparam logic [15:0] ENABLES_ADDR = {ENABLES_IDX[13:0], 2'b00};
  localparam logic [15:0] CTRL_ADDR = 16'h1800;
  localparam logic [15:0] ERR_EN_ADDR = 16'h1840;
  localparam logic [15:0] XSTAT_ADDR = 16'h1844;

  // flag and enable bit positions
  localparam int unsigned BIT_RST_DET = 0;
  localparam int unsigned BIT_ERR = 1;
  localparam int unsigned BIT_SOF = 2;
  localparam int unsigned BIT_TOK = 3;
  localparam int unsigned BIT_IDLE = 4;
  localparam int unsigned BIT_RESUME = 5;
  localparam int unsigned BIT_ATTACH = 6;
  localparam int unsigned BIT_STALL = 7;
  localparam logic [7:0] ATTACH_MASK = 8'h40;

  // control register fields
  localparam int unsigned CTRL_HOST_BIT = 0;
  localparam int unsigned CTRL_LOWSPD_BIT = 1;

  // values after reset
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] ERR_EN_RST = 8'h00;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // transfer status queue
  localparam int unsigned TOK_DEPTH = 4;
  localparam logic [2:0] TOK_FULL = 3'h4;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** hdl/uof_persist.sv ***
// persistence timer: one pulse once a condition has held for LIMIT cycles
`timescale 1ns/100ps
`default_nettype none
module uof_persist #(
  parameter int unsigned LIMIT = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // condition in, pulse out
  input wire logic cond,
  output logic hit
);
  localparam int TW = uof_pkg::TIMER_W;
  localparam logic [TW-1:0] LAST = TW'(LIMIT - 1);

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic fired;
  } uof_persist_st_t;

  uof_persist_st_t s_r;
  uof_persist_st_t s_nxt;

  // fires once per episode; a new episode needs the condition to drop first
  always_comb begin
    s_nxt = s_r;
    hit = 1'b0;
    if (!cond) begin
      s_nxt.cnt = '0;
      s_nxt.fired = 1'b0;
    end else if (!s_r.fired) begin
      if (s_r.cnt == LAST) begin
        s_nxt.fired = 1'b1;
        hit = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // uof_persist
`default_nettype wire

// *** hdl/uof_event_flags.sv ***
// usb otg event flags, enables and transfer status behind an axi4-lite slave
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module uof_event_flags #(
  parameter int unsigned IDLE_CYC = uof_pkg::IDLE_HOLD_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // usb line levels
  input wire logic usb_dp,
  input wire logic usb_dm,
  // protocol engine events
  input wire logic token_done,
  input wire logic [7:0] token_status,
  input wire logic sof_token_rx,
  input wire logic sof_threshold_hit,
  input wire logic stall_sent,
  input wire logic [7:0] err_event,
  // interrupt request
  output logic usb_irq
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [15:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] err_en;
    logic host;
    logic low_speed;
    logic [uof_pkg::TOK_DEPTH-1:0][7:0] tok_mem;
    logic [1:0] tok_rd;
    logic [1:0] tok_wr;
    logic [2:0] tok_cnt;
    logic [1:0] line_prev;
    logic irq;
    logic [15:0] se0_run;
    logic [15:0] k_run;
    logic [15:0] j_run;
  } uof_flags_st_t;

  localparam uof_flags_st_t ST_RST = '{
    flags: uof_pkg::FLAGS_RST,
    enables: uof_pkg::EN_RST,
    err_en: uof_pkg::ERR_EN_RST,
    host: uof_pkg::CTRL_RST[uof_pkg::CTRL_HOST_BIT],
    low_speed: uof_pkg::CTRL_RST[uof_pkg::CTRL_LOWSPD_BIT],
    default: '0
  };

  uof_flags_st_t s_r;
  uof_flags_st_t s_nxt;

  logic se0;
  logic j_st;
  logic k_st;
  logic line_quiet;
  logic se0_hit;
  logic attach_hit;
  logic resume_hit;
  logic idle_hit;
  logic wr_fire;
  logic wr_flags;
  logic [7:0] clr;
  logic [7:0] set;
  logic pop;
  logic push;
  logic [7:0] en_eff;

  // line state decode; K and J swap meaning with the speed setting
  assign se0 = !usb_dp && !usb_dm;
  assign j_st = s_r.low_speed ? (!usb_dp && usb_dm) : (usb_dp && !usb_dm);
  assign k_st = s_r.low_speed ? (usb_dp && !usb_dm) : (!usb_dp && usb_dm);
  assign line_quiet = !se0 && ({usb_dp, usb_dm} == s_r.line_prev);

  // one timer per line condition; each pulses once per episode
  uof_persist #(.LIMIT(uof_pkg::LINE_HOLD_CYC)) u_se0_tmr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cond(se0),
    .hit(se0_hit)
  );
  uof_persist #(.LIMIT(uof_pkg::LINE_HOLD_CYC)) u_attach_tmr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cond(s_r.host && line_quiet),
    .hit(attach_hit)
  );
  uof_persist #(.LIMIT(uof_pkg::LINE_HOLD_CYC)) u_resume_tmr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cond(k_st),
    .hit(resume_hit)
  );
  uof_persist #(.LIMIT(IDLE_CYC)) u_idle_tmr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .cond(j_st),
    .hit(idle_hit)
  );

  // attach enable is still stored, but reads and acts as zero outside host mode
  assign en_eff = s_r.host ? s_r.enables : (s_r.enables & ~uof_pkg::ATTACH_MASK);

  // write commit and flag clear vector
  assign wr_fire = s_r.aw_held && s_r.w_held && !s_r.bvalid;
  assign wr_flags = wr_fire && s_r.w_lane0 && (s_r.aw_addr == uof_pkg::FLAGS_ADDR);
  // whole byte is taken as a clear mask, so stray ones clear too
  assign clr = wr_flags ? s_r.w_data : 8'h00;
  assign pop = clr[uof_pkg::BIT_TOK] && s_r.flags[uof_pkg::BIT_TOK]
               && (s_r.tok_cnt != 3'h0);
  // a full queue drops the newest status rather than stall the engine
  assign push = token_done && ((s_r.tok_cnt != uof_pkg::TOK_FULL) || pop);

  // hardware set sources; only these may raise a flag
  always_comb begin
    set = 8'h00;
    set[uof_pkg::BIT_RST_DET] = se0_hit;
    set[uof_pkg::BIT_ERR] = |(err_event & s_r.err_en);
    set[uof_pkg::BIT_SOF] = s_r.host ? sof_threshold_hit : sof_token_rx;
    set[uof_pkg::BIT_TOK] = push || (pop && (s_r.tok_cnt > 3'h1));
    set[uof_pkg::BIT_IDLE] = idle_hit;
    set[uof_pkg::BIT_RESUME] = resume_hit;
    set[uof_pkg::BIT_ATTACH] = attach_hit;
    set[uof_pkg::BIT_STALL] = !s_r.host && stall_sent;
  end

  // address decode shared by both channels
  function automatic logic addr_known(input logic [15:0] a);
    return (a == uof_pkg::FLAGS_ADDR) || (a == uof_pkg::ENABLES_ADDR)
           || (a == uof_pkg::CTRL_ADDR) || (a == uof_pkg::ERR_EN_ADDR)
           || (a == uof_pkg::XSTAT_ADDR);
  endfunction

  // read mux; narrow registers sit in the low bits, upper bits zero
  function automatic logic [31:0] rd_mux(input logic [15:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      uof_pkg::FLAGS_ADDR: w[7:0] = s_r.flags;
      uof_pkg::ENABLES_ADDR: w[7:0] = en_eff;
      uof_pkg::CTRL_ADDR: w[1:0] = {s_r.low_speed, s_r.host};
      uof_pkg::ERR_EN_ADDR: w[7:0] = s_r.err_en;
      uof_pkg::XSTAT_ADDR: w[7:0] = (|s_r.tok_cnt) ? s_r.tok_mem[s_r.tok_rd] : 8'h00;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.line_prev = {usb_dp, usb_dm};

    // set wins over a clear in the same cycle
    s_nxt.flags = (s_r.flags & ~clr) | set;

    // transfer status queue
    if (push) begin
      s_nxt.tok_mem[s_r.tok_wr] = token_status;
      s_nxt.tok_wr = s_r.tok_wr + 2'h1;
    end
    if (pop) begin
      s_nxt.tok_rd = s_r.tok_rd + 2'h1;
    end
    unique case ({push, pop})
      2'b10: s_nxt.tok_cnt = s_r.tok_cnt + 3'h1;
      2'b01: s_nxt.tok_cnt = s_r.tok_cnt - 3'h1;
      default: s_nxt.tok_cnt = s_r.tok_cnt;
    endcase

    // write address and data are taken in either order
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end

    // register writes; byte lane 0 carries every implemented bit
    if (wr_fire) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = addr_known(s_r.aw_addr) ? uof_pkg::RESP_OKAY : uof_pkg::RESP_SLVERR;
      if (s_r.w_lane0) begin
        unique case (s_r.aw_addr)
          uof_pkg::ENABLES_ADDR: s_nxt.enables = s_r.w_data;
          uof_pkg::ERR_EN_ADDR: s_nxt.err_en = s_r.w_data;
          uof_pkg::CTRL_ADDR: begin
            s_nxt.host = s_r.w_data[uof_pkg::CTRL_HOST_BIT];
            s_nxt.low_speed = s_r.w_data[uof_pkg::CTRL_LOWSPD_BIT];
          end
          default: s_nxt.host = s_r.host;
        endcase
      end
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;

    // read channel; reads have no side effects
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_mux(s_axi_araddr);
      s_nxt.rresp = addr_known(s_axi_araddr) ? uof_pkg::RESP_OKAY : uof_pkg::RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // request follows the next flags so it never lags them
    s_nxt.irq = |(s_nxt.flags & (s_nxt.host ? s_nxt.enables
                 : (s_nxt.enables & ~uof_pkg::ATTACH_MASK)));

    // run lengths of line states, saturating
    s_nxt.se0_run = !se0 ? 16'h0000 : ((&s_r.se0_run) ? s_r.se0_run : s_r.se0_run + 16'h0001);
    s_nxt.k_run = !k_st ? 16'h0000 : ((&s_r.k_run) ? s_r.k_run : s_r.k_run + 16'h0001);
    s_nxt.j_run = !j_st ? 16'h0000 : ((&s_r.j_run) ? s_r.j_run : s_r.j_run + 16'h0001);
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign usb_irq = s_r.irq;

  // checks
  localparam logic [15:0] LINE_LAST = 16'(uof_pkg::LINE_HOLD_CYC - 1);
  localparam logic [15:0] IDLE_LAST = 16'(IDLE_CYC - 1);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence flag_wr_s;
    wr_flags;
  endsequence

  sequence enable_rd_s;
    s_r.arready && s_axi_arvalid && (s_axi_araddr == uof_pkg::ENABLES_ADDR) && !s_r.host;
  endsequence

  sequence both_held_s;
    s_r.aw_held && s_r.w_held && !s_r.bvalid;
  endsequence

  AST_BUS_RESET_TIME: assert property (
    $rose(s_r.flags[0]) && !$past(s_r.host) |-> $past(s_r.se0_run) == LINE_LAST)
    else $error("bus reset flag set at wrong se0 length");

  AST_DETACH_TIME: assert property (
    $rose(s_r.flags[0]) && $past(s_r.host) |-> $past(se0) && $past(s_r.se0_run) == LINE_LAST)
    else $error("detach flag set without held se0");

  AST_ATTACH_CAUSE: assert property (
    $rose(s_r.flags[uof_pkg::BIT_ATTACH]) |-> $past(s_r.host) && !$past(se0))
    else $error("attach flag set outside host mode or during se0");

  AST_RESUME_TIME: assert property (
    $rose(s_r.flags[uof_pkg::BIT_RESUME]) |-> $past(s_r.k_run) == LINE_LAST)
    else $error("resume flag set at wrong k length");

  AST_IDLE_TIME: assert property (
    $rose(s_r.flags[uof_pkg::BIT_IDLE]) |-> $past(s_r.j_run) == IDLE_LAST)
    else $error("idle flag set at wrong idle length");

  AST_TOKEN_ADVANCE: assert property (
    flag_wr_s ##0 (pop && !push && s_r.tok_cnt > 3'h1)
    |=> s_r.flags[uof_pkg::BIT_TOK] && s_r.tok_cnt == $past(s_r.tok_cnt) - 3'h1)
    else $error("token queue did not advance on clear");

  AST_ERR_MASKED: assert property (
    $rose(s_r.flags[uof_pkg::BIT_ERR]) |-> $past(|(err_event & s_r.err_en)))
    else $error("error summary set by masked error");

  AST_STALL_CAUSE: assert property (
    $rose(s_r.flags[uof_pkg::BIT_STALL]) |-> $past(stall_sent) && !$past(s_r.host))
    else $error("stall flag set without device stall");

  AST_ZERO_KEEPS: assert property (
    flag_wr_s |=> ((s_r.flags & $past(s_r.flags & ~s_r.w_data)) == $past(s_r.flags & ~s_r.w_data)))
    else $error("flag written as zero was cleared");

  AST_ATTACH_EN_ZERO: assert property (
    enable_rd_s |=> s_r.rvalid && !s_r.rdata[uof_pkg::BIT_ATTACH])
    else $error("attach enable read as one in device mode");

  AST_IRQ_MATCH: assert property (
    usb_irq == |(s_r.flags & en_eff))
    else $error("interrupt request disagrees with enabled flags");

  AST_WRITE_RESP: assert property (
    both_held_s |=> s_r.bvalid ##0 !s_r.aw_held && !s_r.w_held)
    else $error("write response not given one cycle after commit");

endmodule // uof_event_flags
`default_nettype wire

// *** test/uof_line_model.sv ***
// usb line model: the far party's drive of dp and dm for a commanded state
`timescale 1ns/100ps
`default_nettype none
module uof_line_model (
  // commanded state, 0 se0, 1 j, 2 k
  input wire logic [1:0] line_state,
  input wire logic low_speed,
  // line levels
  output logic usb_dp,
  output logic usb_dm
);
  // low speed swaps the j and k polarity
  always_comb begin
    usb_dp = 1'b0;
    usb_dm = 1'b0;
    if (line_state == 2'h1) begin
      usb_dp = !low_speed;
      usb_dm = low_speed;
    end else if (line_state == 2'h2) begin
      usb_dp = low_speed;
      usb_dm = !low_speed;
    end
  end
endmodule // uof_line_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the usb event flag block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int IDLE_T = 60;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, data, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, usb_irq, usb_dp, usb_dm, low_speed = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, line_state = 2'h1;
  logic token_done = 0, sof_token_rx = 0, sof_threshold_hit = 0, stall_sent = 0;
  logic [7:0] token_status = 8'h00, err_event = 8'h00;
  logic [31:0] seed = 32'h6e2b_fe49;
  int exp_flags = 0, exp_en = 0, host = 0, err_count = 0, samples_checked = 0, cyc = 0, i;
  int tokq[$];

  always #25 clk_sys = ~clk_sys;

  uof_event_flags #(.IDLE_CYC(IDLE_T)) i_uof_event_flags (.clk_sys(clk_sys), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .usb_dp(usb_dp), .usb_dm(usb_dm),
    .token_done(token_done), .token_status(token_status), .sof_token_rx(sof_token_rx),
    .sof_threshold_hit(sof_threshold_hit), .stall_sent(stall_sent), .err_event(err_event),
    .usb_irq(usb_irq));
  uof_line_model i_uof_line_model (.line_state(line_state), .low_speed(low_speed),
    .usb_dp(usb_dp), .usb_dm(usb_dm));

  // xorshift source for status and error patterns
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [15:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input string nm, input logic [31:0] e);
    axr(a);
    chk(nm, e, data);
    chk("rresp", {30'h0, uof_pkg::RESP_OKAY}, {30'h0, resp});
  endtask

  // flags against the model, irq from flags and effective enables
  task automatic cf();
    int ee;
    ee = exp_en & (host ? 8'hff : 8'hbf);
    axr(uof_pkg::FLAGS_ADDR);
    chk("flags", exp_flags, data);
    chk("irq", {31'h0, |(exp_flags & ee)}, {31'h0, usb_irq});
  endtask

  // whole-word clear; clearing token done pops the status queue
  task automatic clr(input int m);
    axw(uof_pkg::FLAGS_ADDR, m);
    chk("bresp", {30'h0, uof_pkg::RESP_OKAY}, {30'h0, resp});
    if ((m & 8) && (exp_flags & 8) && tokq.size() > 0) void'(tokq.pop_front());
    exp_flags &= ~m;
    if (tokq.size() > 0) exp_flags |= 8;
  endtask

  // one-cycle event pulse, k is {token, sof token, sof threshold, stall}
  task automatic ev(input logic [3:0] k, input logic [7:0] e);
    @(posedge clk_sys);
    {token_done, sof_token_rx, sof_threshold_hit, stall_sent} <= k;
    err_event <= e;
    @(posedge clk_sys);
    {token_done, sof_token_rx, sof_threshold_hit, stall_sent} <= 4'h0;
    err_event <= 8'h00;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic ln(input logic [1:0] st, input int n);
    @(posedge clk_sys);
    line_state <= st;
    repeat (n) @(posedge clk_sys);
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(uof_pkg::FLAGS_ADDR, "flags_rst", 0);
    rd(uof_pkg::ENABLES_ADDR, "en_rst", 0);
    axr(16'h1834);
    chk("unmapped", 32'h0000_0002, {data[29:0], resp});
    axw(16'h1834, 32'hffff_ffff);
    chk("unmapped_w", {30'h0, uof_pkg::RESP_SLVERR}, {30'h0, resp});
    repeat (IDLE_T + 10) @(posedge clk_sys);
    exp_flags = 8'h10;
    cf();
    axw(uof_pkg::ENABLES_ADDR, 32'h0000_00ff);
    exp_en = 8'hff;
    rd(uof_pkg::ENABLES_ADDR, "en_dev", 32'h0000_00bf);
    // lane 0 strobe low: the write is answered but must change nothing
    s_axi_wstrb <= 4'he;
    axw(uof_pkg::ENABLES_ADDR, 32'h0000_0000);
    s_axi_wstrb <= 4'hf;
    rd(uof_pkg::ENABLES_ADDR, "en_strb", 32'h0000_00bf);
    cf();
    clr(0);
    cf();
    clr(8'h10);
    cf();
    ev(4'b0100, 8'h00);
    ev(4'b0010, 8'h00);
    ev(4'b0001, 8'h00);
    exp_flags = 8'h84;
    cf();
    clr(8'h04);
    cf();
    clr(8'h80);
    axw(uof_pkg::ERR_EN_ADDR, 32'h0000_0001);
    rd(uof_pkg::ERR_EN_ADDR, "err_en", 32'h0000_0001);
    r = xs();
    ev(4'b0000, r[7:0] & 8'hfe);
    cf();
    ev(4'b0000, 8'h01);
    exp_flags |= 2;
    cf();
    clr(2);
    for (i = 0; i < 5; i++) begin
      r = xs();
      token_status <= r[7:0];
      if (tokq.size() < 4) tokq.push_back(r[7:0]);
      exp_flags |= 8;
      ev(4'b1000, 8'h00);
    end
    for (i = 0; i < 4; i++) begin
      rd(uof_pkg::XSTAT_ADDR, "xstat", tokq[0]);
      cf();
      clr(8);
    end
    cf();
    rd(uof_pkg::XSTAT_ADDR, "xstat_empty", 0);
    ln(2'h0, 55);
    exp_flags = 8'h01;
    cf();
    clr(1);
    ln(2'h0, 60);
    ln(2'h2, 55);
    ln(2'h1, 70);
    exp_flags = 8'h30;
    cf();
    clr(8'h30);
    line_state <= 2'h0;
    axw(uof_pkg::CTRL_ADDR, 32'h0000_0002);
    low_speed <= 1'b1;
    ln(2'h2, 55);
    ln(2'h1, 70);
    exp_flags = 8'h30;
    cf();
    clr(8'h30);
    line_state <= 2'h0;
    axw(uof_pkg::CTRL_ADDR, 32'h0000_0001);
    low_speed <= 1'b0;
    host = 1;
    ln(2'h0, 55);
    exp_flags = 8'h01;
    cf();
    clr(1);
    ln(2'h0, 60);
    ln(2'h1, 70);
    exp_flags = 8'h50;
    cf();
    rd(uof_pkg::ENABLES_ADDR, "en_host", 32'h0000_00ff);
    ev(4'b0100, 8'h00);
    ev(4'b0001, 8'h00);
    cf();
    ev(4'b0010, 8'h00);
    exp_flags |= 4;
    cf();
    axw(uof_pkg::ENABLES_ADDR, 32'h0000_0040);
    exp_en = 8'h40;
    cf();
    clr(8'hff);
    cf();
    // second reset in mid-run: host mode and enables must fall back to zero
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    exp_en = 0;
    host = 0;
    cf();
    rd(uof_pkg::ENABLES_ADDR, "en_rst2", 0);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
